/* pkg/dmia_pkg.sv */
// Package: register map, field layout and sizes of the data-memory addresser
package dmia_pkg;
    localparam logic [7:0] OFS_INDIRECT_PORT_0 = 8'h00;
    localparam logic [7:0] OFS_MEMORY_POINTER_FIRST = 8'h01;
    localparam logic [7:0] OFS_INDIRECT_PORT_1 = 8'h02;
    localparam logic [7:0] OFS_MEMORY_POINTER_SECOND = 8'h03;
    localparam logic [7:0] OFS_BANK_SELECT_REGISTER = 8'h04;
    localparam logic [7:0] OFS_ALU_RESULT_REGISTER = 8'h05;
    localparam logic [7:0] OFS_PROGRAM_COUNTER_LOW_BYTE = 8'h06;
    localparam int BANK_SELECT_BIT_POS = 0;
    localparam logic BANK_SELECT_RESET = 1'h0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] POINTER_TOP_BIT_MASK = 8'h80;
    localparam logic [7:0] DEFAULT_GP_START = 8'h40;
    localparam int PC_WIDTH = 13;

    // Data-memory access request from the execution unit
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmia_req_t;

    // Physical access towards the general-purpose RAM
    typedef struct packed {
        logic rd;
        logic wr;
        logic bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmia_ram_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_DUMMY = 2'h1
    } dmia_state_t;
endpackage : dmia_pkg

/* src/dmia_top.sv */
// Data-memory addressing, pointers, bank select, accumulator and PC low byte
//
// Contract
// RQ1 - An access to an indirect port acts on the location its paired pointer holds.
// RQ2 - The first pointer and its port always reach bank 0.
// RQ3 - The second pointer and its port reach the bank the bank-select bit names.
// RQ4 - Direct addressing always reaches bank 0; bank 1 only via the second pointer.
// RQ5 - The bank choice lives in bit 0 of the bank-select register.
// RQ6 - Every reset returns to bank 0, except a watchdog reset in idle or sleep.
// RQ7 - Special-function locations are reached the same in either bank.
// RQ8 - The pointers are real registers that can be read, written and modified.
// RQ9 - In the smallest configurations pointer bit 7 reads as 1.
// RQ10 - Writing the PC low byte jumps within the page and adds one dummy cycle.
// RQ11 - Every ALU result is placed in the accumulator.
// RQ12 - No register-to-register move; transfers go through the accumulator.
// RQ13 - Reading an indirect port through a pointer gives zero; writing does nothing.
// RQ14 - Reading an unused special-function location returns zero.
// RQ15 - Bank bit 0 means bank 0, 1 means bank 1; it resets to 0, upper bits read 0.
`timescale 1ns/1ps
module dmia_top #(
    parameter logic SMALL_MEMORY = 1'b0,
    parameter logic [7:0] GP_START = dmia_pkg::DEFAULT_GP_START
) (
    input wire logic CLK_IN, // 200 MHz system clock
    input wire logic ARST_N_IN, // Asynchronous reset, active low
    input wire logic WDT_LOWPWR_RESET_IN, // Watchdog reset in idle/sleep
    input wire logic SOFT_RESET_IN, // Other synchronous resets
    input wire dmia_pkg::dmia_req_t REQ_IN, // Data-memory access
    input wire logic ALU_WE_IN, // ALU result strobe
    input wire logic [7:0] ALU_RESULT_IN, // ALU result value
    input wire logic PC_STEP_IN, // Advance program counter
    input wire logic [7:0] RAM_RDATA_IN, // General-purpose RAM read data
    input wire logic [7:0] SFR_RDATA_IN, // Data from other SFRs
    input wire logic SFR_HIT_IN, // Other SFR decodes address
    output dmia_pkg::dmia_ram_t RAM_OUT, // General-purpose RAM access
    output logic SFR_RD_OUT, // Read strobe to other SFRs
    output logic SFR_WR_OUT, // Write strobe to other SFRs
    output logic [7:0] SFR_ADDR_OUT, // Address to other SFRs
    output logic [7:0] RDATA_OUT, // Read data back to core
    output logic [7:0] ACC_OUT, // Accumulator value
    output logic [12:0] PC_OUT, // Program counter
    output logic STALL_OUT, // Dummy cycle in progress
    output logic BANK_OUT // Current bank select
);

    // ****************************************************************
    // Address resolution
    // ****************************************************************
    logic [7:0] memory_pointer_first_q;
    logic [7:0] memory_pointer_second_q;
    logic bank_select_bit_q;
    logic [7:0] alu_result_register_q;
    logic [12:0] pc_q;
    dmia_pkg::dmia_state_t state_q;

    function automatic logic [7:0] ptr_view(input logic [7:0] p);
        ptr_view = SMALL_MEMORY ? (p | dmia_pkg::POINTER_TOP_BIT_MASK) : p;
    endfunction : ptr_view

    function automatic logic is_port(input logic [7:0] a);
        is_port = (a == dmia_pkg::OFS_INDIRECT_PORT_0) ||
                  (a == dmia_pkg::OFS_INDIRECT_PORT_1);
    endfunction : is_port

    logic [7:0] eff_addr;
    logic eff_bank;
    logic via_port;
    logic port_loop;
    logic rd_ok;
    logic wr_ok;

    always_comb begin
        via_port = 1'b0;
        eff_addr = REQ_IN.addr;
        eff_bank = 1'b0; // see RQ4
        if (REQ_IN.addr == dmia_pkg::OFS_INDIRECT_PORT_0) begin
            via_port = 1'b1;
            eff_addr = ptr_view(memory_pointer_first_q); // see RQ1
            eff_bank = 1'b0; // see RQ2
        end else if (REQ_IN.addr == dmia_pkg::OFS_INDIRECT_PORT_1) begin
            via_port = 1'b1;
            eff_addr = ptr_view(memory_pointer_second_q); // see RQ1
            eff_bank = bank_select_bit_q; // see RQ3
        end
        port_loop = via_port && is_port(eff_addr); // see RQ13
        rd_ok = REQ_IN.rd && !port_loop && state_q == dmia_pkg::ST_RUN;
        wr_ok = REQ_IN.wr && !port_loop && state_q == dmia_pkg::ST_RUN;
    end

    logic is_gp;
    logic own_hit;
    assign is_gp = eff_addr >= GP_START;
    // SFR space ignores the bank
    assign own_hit = !is_gp && eff_addr <= dmia_pkg::OFS_PROGRAM_COUNTER_LOW_BYTE
        && !(SMALL_MEMORY && eff_addr == dmia_pkg::OFS_BANK_SELECT_REGISTER);

    always_comb begin
        RAM_OUT.rd = rd_ok && is_gp;
        RAM_OUT.wr = wr_ok && is_gp;
        RAM_OUT.bank = eff_bank; // see RQ7
        RAM_OUT.addr = eff_addr;
        RAM_OUT.wdata = REQ_IN.wdata;
        SFR_RD_OUT = rd_ok && !is_gp && !own_hit;
        SFR_WR_OUT = wr_ok && !is_gp && !own_hit;
        SFR_ADDR_OUT = eff_addr; // see RQ7
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic own_wr;
    assign own_wr = wr_ok && own_hit;

    // Pointers are plain read/write storage
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            memory_pointer_first_q <= dmia_pkg::ZERO_BYTE;
            memory_pointer_second_q <= dmia_pkg::ZERO_BYTE;
        end else if (own_wr) begin
            if (eff_addr == dmia_pkg::OFS_MEMORY_POINTER_FIRST) begin
                memory_pointer_first_q <= REQ_IN.wdata; // see RQ8
            end
            if (eff_addr == dmia_pkg::OFS_MEMORY_POINTER_SECOND) begin
                memory_pointer_second_q <= REQ_IN.wdata; // see RQ8
            end
        end
    end

    // Watchdog reset in low power keeps the bank
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            bank_select_bit_q <= dmia_pkg::BANK_SELECT_RESET; // see RQ6
        end else if (SOFT_RESET_IN && !WDT_LOWPWR_RESET_IN) begin
            bank_select_bit_q <= dmia_pkg::BANK_SELECT_RESET; // see RQ6
        end else if (!WDT_LOWPWR_RESET_IN && own_wr &&
                     eff_addr == dmia_pkg::OFS_BANK_SELECT_REGISTER) begin
            bank_select_bit_q <=
                REQ_IN.wdata[dmia_pkg::BANK_SELECT_BIT_POS]; // see RQ5
        end
    end

    // Accumulator: ALU result wins over a data write in the same cycle
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            alu_result_register_q <= dmia_pkg::ZERO_BYTE;
        end else if (ALU_WE_IN) begin
            alu_result_register_q <= ALU_RESULT_IN; // see RQ11
        end else if (own_wr &&
                     eff_addr == dmia_pkg::OFS_ALU_RESULT_REGISTER) begin
            alu_result_register_q <= REQ_IN.wdata; // see RQ12
        end
    end

    // ****************************************************************
    // Program counter and dummy cycle
    // ****************************************************************
    logic pcl_wr;
    assign pcl_wr = own_wr &&
        eff_addr == dmia_pkg::OFS_PROGRAM_COUNTER_LOW_BYTE;

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pc_q <= 13'h0000;
        end else if (pcl_wr) begin
            pc_q <= {pc_q[12:8], REQ_IN.wdata}; // see RQ10
        end else if (PC_STEP_IN && state_q == dmia_pkg::ST_RUN) begin
            pc_q <= pc_q + 13'h0001;
        end
    end

    // One flush cycle after a computed jump
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state_q <= dmia_pkg::ST_RUN;
        end else begin
            unique case (state_q)
                dmia_pkg::ST_RUN: begin
                    if (pcl_wr) begin
                        state_q <= dmia_pkg::ST_DUMMY; // see RQ10
                    end
                end
                dmia_pkg::ST_DUMMY: begin
                    state_q <= dmia_pkg::ST_RUN;
                end
                default: begin
                    state_q <= dmia_pkg::ST_RUN;
                end
            endcase
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = dmia_pkg::ZERO_BYTE; // see RQ13
        if (!port_loop && is_gp) begin
            rd_mux = RAM_RDATA_IN;
        end else if (!port_loop && own_hit) begin
            unique case (eff_addr)
                dmia_pkg::OFS_MEMORY_POINTER_FIRST:
                    rd_mux = ptr_view(memory_pointer_first_q); // see RQ9
                dmia_pkg::OFS_MEMORY_POINTER_SECOND:
                    rd_mux = ptr_view(memory_pointer_second_q); // see RQ9
                dmia_pkg::OFS_BANK_SELECT_REGISTER:
                    rd_mux = {7'h00, bank_select_bit_q}; // see RQ15
                dmia_pkg::OFS_ALU_RESULT_REGISTER:
                    rd_mux = alu_result_register_q;
                dmia_pkg::OFS_PROGRAM_COUNTER_LOW_BYTE:
                    rd_mux = pc_q[7:0];
                default:
                    rd_mux = dmia_pkg::ZERO_BYTE;
            endcase
        end else if (!port_loop && SFR_HIT_IN) begin
            rd_mux = SFR_RDATA_IN;
        end
    end

    // A read looping back through a port still returns data: zero
    logic rd_take;
    assign rd_take = REQ_IN.rd && state_q == dmia_pkg::ST_RUN; // see RQ13

    // Unused SFR reads come back as zero
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            RDATA_OUT <= dmia_pkg::ZERO_BYTE;
        end else if (rd_take) begin
            RDATA_OUT <= rd_mux; // see RQ14
        end
    end

    assign ACC_OUT = alu_result_register_q;
    assign PC_OUT = pc_q;
    assign STALL_OUT = state_q == dmia_pkg::ST_DUMMY;
    assign BANK_OUT = bank_select_bit_q;

endmodule : dmia_top

/* dv/dmia_top_asserts.sv */
// Checker: port-level properties of the data-memory addresser
`timescale 1ns/1ps
module dmia_asserts #(
    parameter logic SMALL_MEMORY = 1'b0,
    parameter logic [7:0] GP_START = dmia_pkg::DEFAULT_GP_START
) (
    input wire logic CLK_IN, // Clock
    input wire logic ARST_N_IN, // Reset
    input wire logic WDT_LOWPWR_RESET_IN, // Watchdog reset
    input wire dmia_pkg::dmia_req_t REQ_IN, // Access
    input wire logic ALU_WE_IN, // ALU strobe
    input wire logic [7:0] ALU_RESULT_IN, // ALU value
    input wire dmia_pkg::dmia_ram_t RAM_OUT, // RAM access
    input wire logic [7:0] RDATA_OUT, // Read data
    input wire logic [7:0] ACC_OUT, // Accumulator
    input wire logic [12:0] PC_OUT, // Program counter
    input wire logic STALL_OUT, // Dummy cycle
    input wire logic BANK_OUT // Bank select
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    AST_PORT0_BANK0: assert property (
        REQ_IN.addr == 8'h00 && RAM_OUT.rd |-> !RAM_OUT.bank) else $error("p0");
    AST_PORT1_BANK: assert property (
        REQ_IN.addr == 8'h02 && RAM_OUT.rd |-> RAM_OUT.bank == BANK_OUT)
        else $error("port 1 bank");
    AST_DIRECT_BANK0: assert property (
        REQ_IN.rd && !STALL_OUT && REQ_IN.addr >= GP_START |-> RAM_OUT.rd
        && !RAM_OUT.bank && RAM_OUT.addr == REQ_IN.addr) else $error("direct");
    AST_PCL_JUMP: assert property (
        REQ_IN.wr && !STALL_OUT && REQ_IN.addr == 8'h06 |=> STALL_OUT &&
        PC_OUT == {$past(PC_OUT[12:8]), $past(REQ_IN.wdata)}) else $error("pcl");
    AST_DUMMY_ONE: assert property (
        STALL_OUT |=> !STALL_OUT) else $error("dummy cycle too long");
    AST_ALU_ACC: assert property (
        ALU_WE_IN |=> ACC_OUT == $past(ALU_RESULT_IN)) else $error("acc load");
    AST_WDT_HOLD: assert property (
        WDT_LOWPWR_RESET_IN |=> $stable(BANK_OUT)) else $error("bank lost");
    AST_BANK_READ: assert property (
        !SMALL_MEMORY && REQ_IN.rd && !STALL_OUT && REQ_IN.addr == 8'h04
        |=> RDATA_OUT == {7'h00, $past(BANK_OUT)}) else $error("bank read");
endmodule : dmia_asserts
bind dmia_top dmia_asserts #(.SMALL_MEMORY(SMALL_MEMORY), .GP_START(GP_START))
    u_chk (.CLK_IN, .ARST_N_IN, .WDT_LOWPWR_RESET_IN, .REQ_IN, .ALU_WE_IN,
    .ALU_RESULT_IN, .RAM_OUT, .RDATA_OUT, .ACC_OUT, .PC_OUT, .STALL_OUT,
    .BANK_OUT);

/* dv/tb.sv */
// Testbench: directed scenarios for the data-memory addresser
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module tb;
    logic CLK_IN = 1'b0;
    logic ARST_N_IN = 1'b0;
    logic WDT_LOWPWR_RESET_IN = 1'b0;
    logic SOFT_RESET_IN = 1'b0;
    logic ALU_WE_IN = 1'b0;
    logic PC_STEP_IN = 1'b0;
    logic [7:0] ALU_RESULT_IN = 8'h00;
    dmia_pkg::dmia_req_t REQ_IN = '0;
    dmia_pkg::dmia_ram_t RAM_OUT;
    logic [7:0] RAM_RDATA_IN, SFR_RDATA_IN, SFR_ADDR_OUT, RDATA_OUT, ACC_OUT;
    logic SFR_HIT_IN, SFR_RD_OUT, SFR_WR_OUT, STALL_OUT, BANK_OUT;
    logic [12:0] PC_OUT;
    logic [7:0] ram [0:511];
    int fails = 0;
    int total_checks = 0;
    always #2.5 CLK_IN = ~CLK_IN;
    // ****************************************
    // Far side: RAM with both banks, one SFR
    // ****************************************
    assign RAM_RDATA_IN = ram[{RAM_OUT.bank, RAM_OUT.addr}];
    assign SFR_HIT_IN = REQ_IN.addr == 8'h10;
    assign SFR_RDATA_IN = 8'h5A;
    always @(posedge CLK_IN) begin
        if (RAM_OUT.wr) ram[{RAM_OUT.bank, RAM_OUT.addr}] <= RAM_OUT.wdata;
    end
    dmia_top DUT (.*);
    task automatic acc(input logic r, w, input logic [7:0] a, d);
        @(negedge CLK_IN);
        REQ_IN = '{rd: r, wr: w, addr: a, wdata: d};
        @(negedge CLK_IN);
        REQ_IN = '0;
    endtask : acc
    task automatic wr(input logic [7:0] a, d);
        acc(1'b0, 1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, e, input string n);
        acc(1'b1, 1'b0, a, 8'h00);
        `CHK(n, e, RDATA_OUT)
    endtask : rd
    task automatic pulse(ref logic s);
        @(negedge CLK_IN);
        s = 1'b1;
        @(negedge CLK_IN);
        s = 1'b0;
    endtask : pulse
    task automatic t_ptr;
        wr(8'h01, 8'h45);
        rd(8'h01, 8'h45, "pointer0");
        wr(8'h00, 8'h3C);
        `CHK("ram 045", 8'h3C, ram[9'h045])
        rd(8'h00, 8'h3C, "port0");
        $display("t_ptr done");
    endtask : t_ptr
    task automatic t_bank;
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'h01, "bank reg");
        `CHK("bank", 1'b1, BANK_OUT)
        wr(8'h03, 8'h50);
        wr(8'h02, 8'h77);
        `CHK("ram 150", 8'h77, ram[9'h150])
        wr(8'h01, 8'h50);
        wr(8'h00, 8'h11);
        rd(8'h50, 8'h11, "direct");
        rd(8'h10, 8'h5A, "sfr in bank 1");
        pulse(WDT_LOWPWR_RESET_IN);
        `CHK("bank wdt", 1'b1, BANK_OUT)
        pulse(SOFT_RESET_IN);
        `CHK("bank soft", 1'b0, BANK_OUT)
        rd(8'h02, 8'h11, "port1 bank0");
        $display("t_bank done");
    endtask : t_bank
    task automatic t_null;
        wr(8'h01, 8'h02);
        rd(8'h00, 8'h00, "null read");
        wr(8'h00, 8'hEE);
        `CHK("ram 002", 8'hC1, ram[9'h002])
        rd(8'h03, 8'h50, "pointer1");
        rd(8'h20, 8'h00, "unused");
        $display("t_null done");
    endtask : t_null
    task automatic t_sfr;
        @(negedge CLK_IN);
        REQ_IN = '{rd: 1'b0, wr: 1'b1, addr: 8'h1A, wdata: 8'h00};
        #1;
        `CHK("sfr wr", 1'b1, SFR_WR_OUT)
        `CHK("sfr addr", 8'h1A, SFR_ADDR_OUT)
        `CHK("sfr rd", 1'b0, SFR_RD_OUT)
        @(negedge CLK_IN);
        REQ_IN = '{rd: 1'b1, wr: 1'b0, addr: 8'h00, wdata: 8'h00};
        #1;
        `CHK("null sfr rd", 1'b0, SFR_RD_OUT)
        `CHK("null ram rd", 1'b0, RAM_OUT.rd)
        @(negedge CLK_IN);
        REQ_IN = '0;
        $display("t_sfr done");
    endtask : t_sfr
    task automatic t_acc_pc;
        ALU_RESULT_IN = 8'h9C;
        pulse(ALU_WE_IN);
        `CHK("acc", 8'h9C, ACC_OUT)
        rd(8'h05, 8'h9C, "acc read");
        PC_STEP_IN = 1'b1;
        repeat (300) @(negedge CLK_IN);
        PC_STEP_IN = 1'b0;
        wr(8'h06, 8'h34);
        `CHK("stall", 1'b1, STALL_OUT)
        `CHK("pc", 13'h0134, PC_OUT)
        @(negedge CLK_IN);
        `CHK("stall end", 1'b0, STALL_OUT)
        $display("t_acc_pc done");
    endtask : t_acc_pc
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    initial begin
        for (int i = 0; i < 512; i++) ram[i] = i[7:0] ^ 8'hC3;
        repeat (2) @(posedge CLK_IN);
        @(negedge CLK_IN);
        ARST_N_IN = 1'b1;
        `CHK("bank reset", 1'b0, BANK_OUT)
        t_ptr();
        t_bank();
        t_null();
        t_sfr();
        t_acc_pc();
        results();
    end
    // Run needs about 350 cycles; over ten times that is a hang
    initial begin
        #20000;
        fails++;
        results();
    end
endmodule : tb
